// *** include/idw_pkg.sv ***
package idw_pkg;

  // ==========================================================
  // Register offsets (byte addresses on APB)
  localparam logic [7:0] ADDR_INDEX    = 8'h00;
  localparam logic [7:0] ADDR_DATA     = 8'h04;
  localparam logic [7:0] ADDR_UDMA     = 8'h08;
  localparam logic [7:0] ADDR_APM      = 8'h0c;
  localparam logic [7:0] ADDR_PWREV    = 8'h10;
  localparam logic [7:0] ADDR_ERASE    = 8'h14;
  localparam logic [7:0] ADDR_HWRES    = 8'h18;
  localparam logic [7:0] ADDR_SECCFG   = 8'h1c;
  localparam logic [7:0] ADDR_LBA_LO   = 8'h20;
  localparam logic [7:0] ADDR_LBA_HI   = 8'h24;
  localparam logic [7:0] ADDR_EVENT    = 8'h28;
  localparam logic [7:0] ADDR_LOWSUM   = 8'h2c;
  localparam logic [7:0] ADDR_W53      = 8'h30;
  localparam logic [7:0] ADDR_CHKSUM   = 8'h34;

  // ==========================================================
  // Word numbers inside the identify sector
  localparam logic [7:0] W_FIRST = 8'h52;  // 82
  localparam logic [7:0] W_83    = 8'h53;
  localparam logic [7:0] W_84    = 8'h54;
  localparam logic [7:0] W_85    = 8'h55;
  localparam logic [7:0] W_86    = 8'h56;
  localparam logic [7:0] W_87    = 8'h57;
  localparam logic [7:0] W_88    = 8'h58;
  localparam logic [7:0] W_89    = 8'h59;
  localparam logic [7:0] W_90    = 8'h5a;
  localparam logic [7:0] W_91    = 8'h5b;
  localparam logic [7:0] W_92    = 8'h5c;
  localparam logic [7:0] W_93    = 8'h5d;
  localparam logic [7:0] W_100   = 8'h64;
  localparam logic [7:0] W_101   = 8'h65;
  localparam logic [7:0] W_102   = 8'h66;
  localparam logic [7:0] W_103   = 8'h67;
  localparam logic [7:0] W_128   = 8'h80;
  localparam logic [7:0] W_LAST  = 8'hff;  // 255, integrity word

  // ==========================================================
  // Fixed and reset word values
  localparam logic [15:0] VAL_W82   = 16'h746b;
  localparam logic [15:0] VAL_W83   = 16'h7d09;
  localparam logic [15:0] VAL_W84   = 16'h6023;
  localparam logic [15:0] VAL_W85   = 16'h7468;
  localparam logic [15:0] VAL_W86   = 16'h3c09;
  localparam logic [15:0] VAL_W87   = 16'h6023;
  localparam logic [15:0] VAL_W53   = 16'h0007;
  localparam logic [5:0]  UDMA_SUPP = 6'h3f;
  localparam logic [2:0]  UDMA_MAX  = 3'h5;
  localparam logic [7:0]  APM_RST   = 8'h80;
  localparam logic [7:0]  SIG_BYTE  = 8'ha5;  // Low byte of word 255
  localparam logic [2:0]  UNLOCK_TRIES = 3'h5;

  // ==========================================================
  // Field positions
  localparam int unsigned UDMA_EN_BIT  = 3;
  localparam int unsigned EV_SMPW_BIT  = 0;
  localparam int unsigned EV_FAIL_BIT  = 1;

  // Hardware reset result, as written by firmware after reset
  typedef struct packed {
    logic       cable_hi;     // 8
    logic       is_dev1;      // 7
    logic       resp_dev1;    // 6
    logic       dasp_seen;    // 5
    logic       pdiag_seen;   // 4
    logic       diag_pass;    // 3
    logic [1:0] num_method;   // 2:1
    logic       pdiag_drove;  // 0
  } idw_hwres_s;

  typedef struct packed {
    logic level_max;  // 5
    logic enh_erase;  // 4
    logic frozen;     // 3
    logic locked;     // 2
    logic enabled;    // 1
    logic supported;  // 0
  } idw_sec_s;

endpackage

// *** logic/idw_identify_upper.sv ***
// How it works
// R1 - Word 82 reads 746Bh: HPA, security and SMART supported.
// R2 - Word 83 reads 7D09h, bit 15 zero, bit 14 one.
// R3 - Word 84 reads 6023h with logging and self-test bits.
// R4 - Word 85 defaults 7468h, enable mirror of word 82.
// R5 - Word 86 defaults 3C09h, enable mirror of word 83.
// R6 - Word 86 bit 8 sets after a set-max password command.
// R7 - Word 87 reads 6023h.
// R8 - Word 88: modes 0-5 supported, active mode at bit 8+mode.
// R9 - Word 89 holds the erase-time code 0, 1-254 or 255.
// R10 - Word 91 low byte is APM level, high byte zero, reset 80h.
// R11 - Word 92 holds the master password revision code.
// R12 - Word 93 bit 15 zero, 14 one, 13 cable-detect level.
// R13 - As device 1, bits 12-8 give PDIAG, numbering method, one.
// R14 - As device 0, bits 7-0 give reset results and method.
// R15 - Word 94 reads zero.
// R16 - Words 100-103 give the current 48-bit maximum LBA.
// R17 - Words 127 and 160 read zero.
// R18 - Words 176-205 read zero.
// R19 - Word 128 reports level, enhanced erase, frozen, locked, etc.
// R20 - Exhausted unlock tries set bit 4 and abort until reset.
// R21 - Word 255 high byte makes the 512-byte sum zero.
// R22 - Word 53 bit 2 stays set.
// R23 - Reserved words read zero.
// R24 - Host checks the checksum before trusting the sector.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps

module idw_identify_upper (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             sec_abort
);
  import idw_pkg::*;

  // ==========================================================
  // Configuration state
  logic [7:0]  index_reg,  index_next;
  logic [5:0]  udma_reg,   udma_next;
  logic [7:0]  apm_reg,    apm_next;
  logic [15:0] pwrev_reg,  pwrev_next;
  logic [15:0] erase_reg,  erase_next;
  idw_hwres_s  hwres_reg,  hwres_next;
  idw_sec_s    sec_reg,    sec_next;
  logic [31:0] lba_lo_reg, lba_lo_next;
  logic [15:0] lba_hi_reg, lba_hi_next;
  logic [7:0]  lowsum_reg, lowsum_next;
  logic        smext_reg,  smext_next;
  logic [2:0]  fail_reg,   fail_next;
  logic        expd_reg,   expd_next;
  logic [7:0]  chk_reg,    chk_next;

  logic        wr_en;
  logic [15:0] id_word;
  logic [15:0] w86, w88, w93, w128;

  assign wr_en = psel & penable & pwrite & pready;

  // ==========================================================
  // Register writes and hardware events
  always_comb begin
    index_next  = index_reg;
    udma_next   = udma_reg;
    apm_next    = apm_reg;
    pwrev_next  = pwrev_reg;
    erase_next  = erase_reg;
    hwres_next  = hwres_reg;
    sec_next    = sec_reg;
    lba_lo_next = lba_lo_reg;
    lba_hi_next = lba_hi_reg;
    lowsum_next = lowsum_reg;
    smext_next  = smext_reg;
    fail_next   = fail_reg;
    expd_next   = expd_reg;
    if (wr_en) begin
      case (paddr)
        ADDR_INDEX:  index_next  = pwdata[7:0];
        ADDR_UDMA: begin
          // Out-of-range modes are ignored; enable low deselects all
          if (!pwdata[UDMA_EN_BIT]) begin
            udma_next = '0; // R8
          end else if (pwdata[2:0] <= UDMA_MAX) begin
            udma_next = 6'h01 << pwdata[2:0]; // R8
          end
        end
        ADDR_APM:    apm_next    = pwdata[7:0]; // R10
        ADDR_PWREV:  pwrev_next  = pwdata[15:0]; // R11
        ADDR_ERASE:  erase_next  = pwdata[15:0]; // R9
        ADDR_HWRES:  hwres_next  = idw_hwres_s'(pwdata[8:0]);
        ADDR_SECCFG: sec_next    = idw_sec_s'(pwdata[5:0]);
        ADDR_LBA_LO: lba_lo_next = pwdata;
        ADDR_LBA_HI: lba_hi_next = pwdata[15:0];
        ADDR_LOWSUM: lowsum_next = pwdata[7:0];
        ADDR_EVENT: begin
          if (pwdata[EV_SMPW_BIT]) begin
            smext_next = 1'b1; // R6
          end
          // Only a reset clears the expired state
          if (pwdata[EV_FAIL_BIT] && !expd_reg) begin
            fail_next = fail_reg + 3'h1;
            if (fail_reg + 3'h1 == UNLOCK_TRIES) begin
              expd_next = 1'b1; // R20
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      index_reg  <= W_FIRST;
      udma_reg   <= '0;
      apm_reg    <= APM_RST; // R10
      pwrev_reg  <= '0;
      erase_reg  <= '0;
      hwres_reg  <= '0;
      sec_reg    <= '0;
      lba_lo_reg <= '0;
      lba_hi_reg <= '0;
      lowsum_reg <= '0;
      smext_reg  <= 1'b0;
      fail_reg   <= '0;
      expd_reg   <= 1'b0; // R20
    end else begin
      index_reg  <= index_next;
      udma_reg   <= udma_next;
      apm_reg    <= apm_next;
      pwrev_reg  <= pwrev_next;
      erase_reg  <= erase_next;
      hwres_reg  <= hwres_next;
      sec_reg    <= sec_next;
      lba_lo_reg <= lba_lo_next;
      lba_hi_reg <= lba_hi_next;
      lowsum_reg <= lowsum_next;
      smext_reg  <= smext_next;
      fail_reg   <= fail_next;
      expd_reg   <= expd_next;
    end
  end

  // ==========================================================
  // Composed sector words
  always_comb begin
    w86 = VAL_W86 | {7'h00, smext_reg, 8'h00}; // R5 R6
    w88 = {2'h0, udma_reg, 2'h0, UDMA_SUPP}; // R8
    w93 = {1'b0, 1'b1, hwres_reg.cable_hi, 13'h0000}; // R12
    if (hwres_reg.is_dev1) begin
      w93[12:8] = {1'b0, hwres_reg.pdiag_drove,
                   hwres_reg.num_method, 1'b1}; // R13
    end else begin
      w93[7:0] = {1'b0, hwres_reg.resp_dev1, hwres_reg.dasp_seen,
                  hwres_reg.pdiag_seen, hwres_reg.diag_pass,
                  hwres_reg.num_method, 1'b1}; // R14
    end
    w128 = {7'h00, sec_reg.level_max, 2'h0, sec_reg.enh_erase,
            expd_reg, sec_reg.frozen, sec_reg.locked,
            sec_reg.enabled, sec_reg.supported}; // R19 R20
  end

  function automatic logic [7:0] bsum(input logic [15:0] w);
    bsum = w[15:8] + w[7:0];
  endfunction

  // Only the non-zero words take part; all others are zero
  always_comb begin
    logic [7:0] s;
    s = lowsum_reg + SIG_BYTE;
    s = s + bsum(VAL_W82) + bsum(VAL_W83) + bsum(VAL_W84);
    s = s + bsum(VAL_W85) + bsum(w86) + bsum(VAL_W87);
    s = s + bsum(w88) + bsum(erase_reg) + bsum({8'h00, apm_reg});
    s = s + bsum(pwrev_reg) + bsum(w93) + bsum(w128);
    s = s + bsum(lba_lo_reg[15:0]) + bsum(lba_lo_reg[31:16]);
    s = s + bsum(lba_hi_reg);
    chk_next = 8'h00 - s; // R21
  end

  // Checksum is registered to keep the adder tree off the bus path
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chk_reg <= '0;
    end else begin
      chk_reg <= chk_next;
    end
  end

  always_comb begin
    case (index_reg)
      W_FIRST: id_word = VAL_W82; // R1
      W_83:    id_word = VAL_W83; // R2
      W_84:    id_word = VAL_W84; // R3
      W_85:    id_word = VAL_W85; // R4
      W_86:    id_word = w86;
      W_87:    id_word = VAL_W87; // R7
      W_88:    id_word = w88;
      W_89:    id_word = {8'h00, erase_reg[7:0]}; // R9
      W_90:    id_word = {8'h00, erase_reg[15:8]};
      W_91:    id_word = {8'h00, apm_reg}; // R10
      W_92:    id_word = pwrev_reg; // R11
      W_93:    id_word = w93;
      W_100:   id_word = lba_lo_reg[15:0]; // R16
      W_101:   id_word = lba_lo_reg[31:16]; // R16
      W_102:   id_word = lba_hi_reg; // R16
      W_103:   id_word = '0;
      W_128:   id_word = w128;
      W_LAST:  id_word = {chk_reg, SIG_BYTE}; // R21
      // Words 94, 127, 160, 176-205 and all reserved words
      default: id_word = '0; // R15 R17 R18 R23
    endcase
  end

  // ==========================================================
  // APB slave: read data captured in the setup cycle, so the
  // access phase completes with no wait state
  logic [31:0] rd_next;
  logic        err_next;

  always_comb begin
    rd_next  = '0;
    err_next = 1'b0;
    case (paddr)
      ADDR_INDEX:  rd_next = {24'h000000, index_reg};
      ADDR_DATA:   rd_next = {16'h0000, id_word};
      ADDR_UDMA:   rd_next = {16'h0000, w88};
      ADDR_APM:    rd_next = {24'h000000, apm_reg};
      ADDR_PWREV:  rd_next = {16'h0000, pwrev_reg};
      ADDR_ERASE:  rd_next = {16'h0000, erase_reg};
      ADDR_HWRES:  rd_next = {23'h000000, hwres_reg};
      ADDR_SECCFG: rd_next = {26'h0000000, sec_reg};
      ADDR_LBA_LO: rd_next = lba_lo_reg;
      ADDR_LBA_HI: rd_next = {16'h0000, lba_hi_reg};
      ADDR_EVENT:  rd_next = {27'h0000000, fail_reg, expd_reg,
                              smext_reg};
      ADDR_LOWSUM: rd_next = {24'h000000, lowsum_reg};
      ADDR_W53:    rd_next = {16'h0000, VAL_W53}; // R22
      ADDR_CHKSUM: rd_next = {24'h000000, chk_reg};
      default:     err_next = 1'b1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      sec_abort <= 1'b0;
    end else begin
      pready    <= psel & ~penable;
      prdata    <= (psel & ~penable & ~pwrite) ? rd_next : '0;
      pslverr   <= psel & ~penable & err_next;
      sec_abort <= expd_next; // R20
    end
  end

endmodule

// *** dv/idw_assertions.sv ***
`timescale 1ns/10ps
module idw_assertions
  import idw_pkg::*;
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sec_abort
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic ev_fail = psel && penable && pwrite &&
                       paddr == ADDR_EVENT && pwdata[EV_FAIL_BIT];
  // ==========================================================
  // Bus timing
  AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
    else $error("setup not answered");
  AST_ERR_UNMAPPED: assert property (pready && paddr > 8'h34 |-> pslverr)
    else $error("unmapped access accepted");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error outside access");
  AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero when idle");
  // ==========================================================
  // Content and security state
  AST_W53: assert property (pready && !pwrite && paddr == ADDR_W53
    |-> prdata == 32'h0000_0007) else $error("word 53 wrong");
  AST_ABORT_STICKY: assert property (sec_abort |=> sec_abort)
    else $error("abort cleared without reset");
  AST_ABORT_CAUSE: assert property ($rose(sec_abort)
    |-> $past(ev_fail) || $past(ev_fail, 2)) else $error("abort uncaused");
  cover property (pslverr);
  cover property ($rose(sec_abort));
  cover property (pready && pwrite && paddr == ADDR_UDMA);
endmodule

bind idw_identify_upper idw_assertions idw_assertions_i (.mclk(mclk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sec_abort(sec_abort));

// *** dv/idw_host_model.sv ***
`timescale 1ns/10ps
module idw_host_model
  import idw_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic [7:0]       paddr = 8'h0,
  output logic [31:0]      pwdata = 32'h0
);
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so stale values never look valid
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic word(input logic [7:0] n, output logic [15:0] v);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, ADDR_INDEX, {24'h0, n}, r, e);
    xfer(1'b0, ADDR_DATA, 32'h0, r, e);
    v = r[15:0];
  endtask
  // Byte sum of the whole sector; zero means the data can be trusted
  task automatic sum(input logic [7:0] low, output logic [7:0] s);
    logic [15:0] v;
    s = low;
    for (int i = 82; i < 256; i++) begin
      word(i[7:0], v);
      s = s + v[7:0] + v[15:8];
    end
  endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  mismatches++; $display("unexpected %0t: %h not %h", $time, a, b); end end
module tb;
  import idw_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, sec_abort, e;
  logic [7:0]  paddr, s;
  logic [31:0] pwdata, prdata, r, q;
  logic [15:0] v;
  logic [2:0]  m;
  logic [8:0]  h;
  int          mismatches = 0;
  int          n_compared = 0;
  logic [15:0] fx[6] = '{VAL_W82, VAL_W83, VAL_W84, VAL_W85, VAL_W86,
                         VAL_W87};
  logic [7:0]  zw[8] = '{94, 95, 99, 127, 160, 176, 205, 254};
  always #10 mclk = ~mclk;
  idw_identify_upper idw_identify_upper_i (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sec_abort(sec_abort));
  idw_host_model host_i (.mclk(mclk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  function automatic logic [15:0] w93(input logic [8:0] h);
    w93 = {2'b01, h[8], 13'h0};
    if (h[7]) w93[12:8] = {1'b0, h[0], h[2:1], 1'b1};
    else w93[7:0] = {1'b0, h[6:3], h[2:1], 1'b1};
  endfunction
  function automatic logic [15:0] w128(input logic [5:0] c, input logic x);
    w128 = {7'h0, c[5], 2'b0, c[4], x, c[3:0]};
  endfunction
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(20 * 40000);
    mismatches++;
    test_done;
  end
  initial begin
    void'($urandom(6306));
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (fx[i]) begin
      host_i.word(8'h52 + 8'(i), v);
      `CHK(v, fx[i])
    end
    foreach (zw[i]) begin
      host_i.word(zw[i], v);
      `CHK(v, 16'h0)
    end
    host_i.word(W_88, v);
    `CHK(v, 16'h003f)
    host_i.word(W_91, v);
    `CHK(v, 16'h0080)
    for (int i = 0; i < 4; i++) begin
      m = 3'($urandom_range(5));
      r = $urandom;
      q = $urandom;
      h = {r[8], i[0], r[6:0]};
      host_i.wr(ADDR_UDMA, {29'h1, m});
      host_i.wr(ADDR_UDMA, {29'h1, 3'h6 | 3'(i)});
      host_i.word(W_88, v);
      `CHK(v, 16'h003f | (16'h0100 << m))
      host_i.wr(ADDR_APM, {24'h0, r[7:0]});
      host_i.wr(ADDR_PWREV, {16'h0, r[15:0]});
      host_i.wr(ADDR_ERASE, {16'h0, r[31:16]});
      host_i.wr(ADDR_HWRES, {23'h0, h});
      host_i.wr(ADDR_SECCFG, {26'h0, r[5:0]});
      host_i.wr(ADDR_LBA_LO, q);
      host_i.wr(ADDR_LBA_HI, {16'h0, r[15:0]});
      host_i.wr(ADDR_LOWSUM, {24'h0, q[7:0]});
      host_i.word(W_91, v);
      `CHK(v, {8'h0, r[7:0]})
      host_i.word(W_92, v);
      `CHK(v, r[15:0])
      host_i.word(W_89, v);
      `CHK(v, {8'h0, r[23:16]})
      host_i.word(W_90, v);
      `CHK(v, {8'h0, r[31:24]})
      host_i.word(W_93, v);
      `CHK(v, w93(h))
      host_i.word(W_128, v);
      `CHK(v, w128(r[5:0], 1'b0))
      host_i.word(W_100, v);
      `CHK(v, q[15:0])
      host_i.word(W_101, v);
      `CHK(v, q[31:16])
      host_i.word(W_102, v);
      `CHK(v, r[15:0])
      host_i.word(W_103, v);
      `CHK(v, 16'h0)
      host_i.sum(q[7:0], s);
      `CHK(s, 8'h0)
    end
    host_i.wr(ADDR_EVENT, 32'h1);
    host_i.word(W_86, v);
    `CHK(v, 16'h3d09)
    repeat (4) host_i.wr(ADDR_EVENT, 32'h2);
    @(negedge mclk);
    `CHK(sec_abort, 1'b0)
    host_i.wr(ADDR_EVENT, 32'h2);
    repeat (3) @(negedge mclk);
    `CHK(sec_abort, 1'b1)
    host_i.word(W_128, v);
    `CHK(v, w128(r[5:0], 1'b1))
    host_i.sum(q[7:0], s);
    `CHK(s, 8'h0)
    host_i.xfer(1'b0, ADDR_W53, 32'h0, r, e);
    `CHK({e, r}, {1'b0, 32'h0000_0007})
    host_i.xfer(1'b0, 8'h3c, 32'h0, r, e);
    `CHK({e, r}, {1'b1, 32'h0})
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    `CHK(sec_abort, 1'b0)
    host_i.word(W_128, v);
    `CHK(v, 16'h0)
    host_i.word(W_91, v);
    `CHK(v, 16'h0080)
    test_done;
  end
endmodule
